/* bench/pbs_front_os_model.sv */
// Purpose: Front panel switch and operating system stand-in
// Assumes: Driven 2 ns after the rising edge
// Notes: Requests are one-cycle pulses, standby is a level
`timescale 1ns/100ps
module pbs_front_os_model (
    // Clock
    input wire logic ref_clk,
    // Switch and requests
    output logic switch_pressed,
    output pbs_pkg::pbs_os_req_t os_req
);
    import pbs_pkg::*;
    // Idle at time zero
    initial begin
        switch_pressed = 1'b0;
        os_req = '0;
    end
    // Hold the switch for n sampled edges
    task automatic hold(input int n);
        @(posedge ref_clk) #2;
        switch_pressed = 1'b1;
        repeat (n) @(posedge ref_clk);
        #2 switch_pressed = 1'b0;
    endtask : hold
    // One-cycle pulse: 0 off, 1 S3, 2 S4, 3 S1
    task automatic pulse(input int kind);
        @(posedge ref_clk) #2;
        os_req.soft_off = (kind == 0);
        os_req.sleep_s3 = (kind == 1);
        os_req.sleep_s4 = (kind == 2);
        os_req.sleep_s1 = (kind == 3);
        @(posedge ref_clk) #2;
        os_req[4:1] = 4'h0;
    endtask : pulse
    // Switch action level set by the OS
    task automatic standby(input logic v);
        @(posedge ref_clk) #2;
        os_req.btn_standby = v;
    endtask : standby
endmodule : pbs_front_os_model

/* bench/test_power_button_sleep_state_control.sv */
// Purpose: Self-checking bench for the sleep-state controller
// Assumes: Short counts shrunk to 8 and 12 cycles
// Notes: Expected rails come from a bench function
`timescale 1ns/100ps
module test_power_button_sleep_state_control;
    import pbs_pkg::*;
    localparam logic [31:0] SHORT = 32'h8; // Short press limit
    localparam logic [31:0] LONG = 32'hC; // Fail-safe threshold
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic switch_pressed;
    pbs_os_req_t os_req;
    logic mgmt_engine_s0_only_package = 1'b0;
    pbs_state_t sys_state;
    pbs_rails_t rails;
    logic deep_sx_enable;
    logic oob_mgmt_enable;
    logic req_rejected;
    logic seen_rej = 1'b0; // Refusal pulse seen
    pbs_state_t slp; // Sleep state picked at random
    int miscompares = 0;
    int total_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    pbs_front_os_model panel (.ref_clk(ref_clk), .switch_pressed(switch_pressed), .os_req(os_req));
    pbs_sleep_ctrl #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .switch_pressed(switch_pressed), .os_req(os_req), .mgmt_engine_s0_only_package(mgmt_engine_s0_only_package),
        .sys_state(sys_state), .rails(rails), .deep_sx_enable(deep_sx_enable), .oob_mgmt_enable(oob_mgmt_enable),
        .req_rejected(req_rejected));
    // Latch any refusal pulse
    always @(posedge ref_clk) if (req_rejected === 1'b1) seen_rej <= 1'b1;
    // Rails expected in each state
    function automatic pbs_rails_t exp_rails(input pbs_state_t s);
        pbs_rails_t r;
        r.main_rails = (s == PBS_S0);
        r.cpu_power = (s == PBS_S0);
        r.ram_selfref = (s == PBS_S3);
        r.ctx_disk = (s == PBS_S4);
        r.cold_boot = (s == PBS_S5);
        return r;
    endfunction : exp_rails
    task automatic cmp_bit(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : cmp_bit
    // State and its rails together
    task automatic cmp_state(input pbs_state_t e);
        total_checks++;
        if (sys_state !== e || rails !== exp_rails(e)) begin
            miscompares++;
            $display("mismatch state expected %0d/%b seen %0d/%b", e, exp_rails(e), sys_state, rails);
        end
    endtask : cmp_state
    // Bounded wait for a state, then compare
    task automatic go(input pbs_state_t e, input int lim);
        for (int i = 0; i < lim && sys_state !== e; i++) begin
            @(posedge ref_clk);
            #2;
        end
        cmp_state(e);
    endtask : go
    // Let n edges pass, then the state must not have moved
    task automatic stay(input pbs_state_t e, input int n);
        repeat (n) @(posedge ref_clk);
        #2 cmp_state(e);
    endtask : stay
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    // Watchdog
    initial begin
        repeat (4000) @(posedge ref_clk);
        miscompares++;
        $display("watchdog expired");
        end_of_test();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hA0DB971D));
        repeat (10) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        cmp_state(PBS_S5);
        cmp_bit("oob", 1'b1, oob_mgmt_enable);
        panel.hold(1);
        go(PBS_S0, 6);
        panel.hold(int'(SHORT) - 1);
        stay(PBS_S0, 3);
        $display("test wake and unconfigured press done");
        panel.hold(int'(SHORT));
        stay(PBS_S0, 3);
        panel.hold(int'(LONG) - 1);
        stay(PBS_S0, 3);
        panel.standby(1'b1);
        panel.hold(int'(SHORT) - 1);
        go(PBS_S3, 6);
        panel.hold(3);
        go(PBS_S0, 6);
        seen_rej = 1'b0;
        panel.pulse(3);
        repeat (3) @(posedge ref_clk);
        #2 cmp_bit("rejected", 1'b1, seen_rej);
        cmp_state(PBS_S0);
        $display("test standby and refusal done");
        for (int n = 0; n < 8; n++) begin
            slp = ($urandom_range(1, 0) == 1) ? PBS_S3 : PBS_S4;
            panel.pulse((slp == PBS_S3) ? 1 : 2);
            go(slp, 3);
            seen_rej = 1'b0;
            panel.pulse($urandom_range(3, 0));
            repeat (2) @(posedge ref_clk);
            #2 cmp_bit("rejected", 1'b0, seen_rej);
            cmp_state(slp);
            panel.hold($urandom_range(int'(SHORT) - 1, 1));
            go(PBS_S0, 6);
        end
        $display("test random sleeps done");
        panel.pulse(0);
        go(PBS_S5, 3);
        panel.hold(int'(SHORT));
        stay(PBS_S5, 3);
        panel.hold(1);
        go(PBS_S0, 6);
        fork
            panel.hold(int'(LONG) + 6);
            go(PBS_S5, int'(LONG) + 5);
        join
        stay(PBS_S5, 3);
        for (int k = 1; k <= 2; k++) begin
            panel.hold(1);
            go(PBS_S0, 6);
            panel.pulse(k);
            go((k == 1) ? PBS_S3 : PBS_S4, 3);
            fork
                panel.hold(int'(LONG) + 2);
                go(PBS_S5, int'(LONG) + 5);
            join
        end
        repeat (4) @(posedge ref_clk);
        #2 cmp_state(PBS_S5);
        $display("test fail-safe off done");
        for (int k = 0; k < 6; k++) begin
            @(posedge ref_clk) #2;
            mgmt_engine_s0_only_package = (k == 1) ? 1'b0 : (k == 0 || k == 5) ? 1'b1 : 1'($urandom_range(1, 0));
            @(posedge ref_clk) #2;
            cmp_bit("deep", mgmt_engine_s0_only_package, deep_sx_enable);
            cmp_bit("oob", !mgmt_engine_s0_only_package, oob_mgmt_enable);
        end
        panel.hold(1);
        go(PBS_S0, 6);
        @(posedge ref_clk) #2;
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        cmp_state(PBS_S5);
        cmp_bit("deep", 1'b0, deep_sx_enable);
        cmp_bit("oob", 1'b1, oob_mgmt_enable);
        cmp_bit("rejected", 1'b0, req_rejected);
        panel.hold(1);
        go(PBS_S0, 6);
        cmp_bit("deep", 1'b1, deep_sx_enable);
        $display("test package select and reset done");
        end_of_test();
    end
endmodule : test_power_button_sleep_state_control

/* design/pbs_hold_timer.sv */
// Purpose: Time power switch holds and classify presses
// Assumes: Switch input is debounced and synchronous
// Notes: Holds between the two limits give nothing
`timescale 1ns/100ps
`include "pbs_defines.svh"
module pbs_hold_timer #(
    parameter logic [`PBS_CNT_W-1:0] SHORT_CYCLES = `PBS_CNT_W'(`PBS_SHORT_CYCLES),
    parameter logic [`PBS_CNT_W-1:0] LONG_CYCLES = `PBS_CNT_W'(`PBS_LONG_CYCLES)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Switch
    input wire logic switch_pressed,
    // Events
    output pbs_pkg::pbs_press_t press
);
    import pbs_pkg::*;
    // ************************************************************
    // Hold counting
    // ************************************************************
    logic [`PBS_CNT_W-1:0] hold_cnt; // Cycles held so far
    logic fired;                     // Long hold already reported
    // Count while pressed, clear on release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_cnt <= '0;
        end else if (!switch_pressed) begin
            hold_cnt <= '0;
        end else if (hold_cnt != LONG_CYCLES) begin
            hold_cnt <= hold_cnt + `PBS_CNT_W'(1);
        end
    end
    // Report long hold once per press
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fired <= 1'b0;
        end else if (!switch_pressed) begin
            fired <= 1'b0;
        end else if (hold_cnt == LONG_CYCLES) begin
            fired <= 1'b1;
        end
    end
    // Classify: short on release, long at threshold, middle band idle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            press <= '0;
        end else begin
            press.short_press <= !switch_pressed && hold_cnt != '0 && hold_cnt < SHORT_CYCLES;
            press.long_hold <= switch_pressed && hold_cnt == LONG_CYCLES && !fired;
        end
    end
    // ************************************************************
    // Checks
    // ************************************************************
    chk_middle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!switch_pressed && hold_cnt >= SHORT_CYCLES) |=> !press.short_press)
        else $error("short press reported after long hold");
    chk_long_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
        press.long_hold |=> !press.long_hold)
        else $error("long hold reported twice");
endmodule : pbs_hold_timer

/* design/pbs_sleep_ctrl.sv */
// Purpose: Move the system among working, sleeping and soft-off states
// Assumes: Requests are single-cycle pulses synchronous to ref_clk
// Notes: Deep processor sleep gated by management package choice
`timescale 1ns/100ps
`include "pbs_defines.svh"
module pbs_sleep_ctrl #(
    parameter logic [`PBS_CNT_W-1:0] SHORT_CYCLES = `PBS_CNT_W'(`PBS_SHORT_CYCLES),
    parameter logic [`PBS_CNT_W-1:0] LONG_CYCLES = `PBS_CNT_W'(`PBS_LONG_CYCLES)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Front panel switch
    input wire logic switch_pressed,
    // Operating system requests
    input pbs_pkg::pbs_os_req_t os_req,
    // Setup selection
    input wire logic mgmt_engine_s0_only_package,
    // State and rails
    output pbs_pkg::pbs_state_t sys_state,
    output pbs_pkg::pbs_rails_t rails,
    output logic deep_sx_enable,
    output logic oob_mgmt_enable,
    output logic req_rejected
);
    import pbs_pkg::*;
    // ************************************************************
    // Press timing
    // ************************************************************
    pbs_press_t press; // Classified switch events
    // The timer reports a short press on the release edge and a long hold
    // while the switch is still down, so the two never meet in one cycle
    // Holds that end between the two limits produce no event at all
    // Hold timer instance
    pbs_hold_timer #(
        .SHORT_CYCLES(SHORT_CYCLES),
        .LONG_CYCLES(LONG_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .switch_pressed(switch_pressed),
        .press(press)
    );
    // ************************************************************
    // State selection
    // ************************************************************
    pbs_state_t next_state; // Next system state
    // A user who keeps the switch down is overriding software, so the
    // fail-safe hold outranks every request the operating system makes
    // Requests arriving outside the working state are ignored, and a
    // processor-stopped request never selects a state at all
    // Transition priority: long hold, OS off, sleeps, short press
    always_comb begin
        next_state = sys_state;
        case (sys_state)
            PBS_S0: begin
                if (press.long_hold) begin
                    next_state = PBS_S5;
                end else if (os_req.soft_off) begin
                    next_state = PBS_S5;
                end else if (os_req.sleep_s4) begin
                    next_state = PBS_S4;
                end else if (os_req.sleep_s3) begin
                    next_state = PBS_S3;
                end else if (press.short_press && os_req.btn_standby) begin
                    next_state = PBS_S3;
                end
            end
            PBS_S3, PBS_S4: begin
                if (press.long_hold) begin
                    next_state = PBS_S5;
                end else if (press.short_press) begin
                    next_state = PBS_S0;
                end
            end
            PBS_S5: begin
                if (press.short_press) begin
                    next_state = PBS_S0;
                end
            end
            // Processor-stopped and unused codes fall back to working,
            // so a corrupted state register cannot park the system
            default: begin
                next_state = PBS_S0; // S1 is never held
            end
        endcase
    end
    // Reset lands in soft-off: the rails are down and the next wake
    // has to go through a cold boot, just as after a power loss
    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sys_state <= PBS_S5;
        end else begin
            sys_state <= next_state;
        end
    end
    // Software asking for the processor-stopped state in the working state gets a
    // one-cycle refusal pulse instead of a silent drop, so it can pick another state
    // Flag a processor-stopped request made in the working state, which is refused
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_rejected <= 1'b0;
        end else begin
            req_rejected <= os_req.sleep_s1 && sys_state == PBS_S0;
        end
    end
    // ************************************************************
    // Rails and context
    // ************************************************************
    // Decoding from the next state keeps rails and sys_state changing on
    // one edge; decoding from sys_state would leave a cycle of stale rails
    // Exactly one of cpu_power, ram_selfref, ctx_disk, cold_boot is high
    // Rail pattern follows the next state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rails <= '{main_rails: 1'b0, cpu_power: 1'b0, ram_selfref: 1'b0, ctx_disk: 1'b0, cold_boot: 1'b1};
        end else begin
            rails.main_rails <= next_state == PBS_S0;
            rails.cpu_power <= next_state == PBS_S0;
            rails.ram_selfref <= next_state == PBS_S3;
            rails.ctx_disk <= next_state == PBS_S4;
            rails.cold_boot <= next_state == PBS_S5;
        end
    end
    // Choosing the working-state-only package buys the deepest sleep
    // states but gives up out-of-band management, including its wake path,
    // so the two outputs are always complements
    // Management package selection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            deep_sx_enable <= 1'b0;
            oob_mgmt_enable <= 1'b1;
        end else begin
            deep_sx_enable <= mgmt_engine_s0_only_package;
            oob_mgmt_enable <= !mgmt_engine_s0_only_package;
        end
    end
    // ************************************************************
    // Checks
    // ************************************************************
    // All checks run on ref_clk; the assertions rest while reset is held, the covers do not
    // Rails are compared with the state they belong to, not with inputs
    // Switch events
    chk_short_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (press.short_press && !press.long_hold && (sys_state == PBS_S5 || sys_state == PBS_S3
        || sys_state == PBS_S4)) |=> sys_state == PBS_S0)
        else $error("short press did not wake");
    chk_wake_rails: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S5 && press.short_press) |=> rails.main_rails && rails.cpu_power && !rails.cold_boot)
        else $error("wake from soft-off left rails down");
    chk_long_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (press.long_hold && sys_state != PBS_S5) |=> sys_state == PBS_S5 ##1 rails.cold_boot)
        else $error("long hold did not power off");
    chk_standby_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S0 && press.short_press && !os_req.btn_standby && !os_req.soft_off
        && !os_req.sleep_s3 && !os_req.sleep_s4) |=> sys_state == PBS_S0)
        else $error("unconfigured press put system to sleep");
    chk_sleep_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((sys_state == PBS_S3 || sys_state == PBS_S4) && !press.short_press && !press.long_hold)
        |=> $stable(sys_state))
        else $error("sleep state left without a switch event");
    // Operating system requests
    chk_os_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S0 && os_req.soft_off) |=> sys_state == PBS_S5)
        else $error("soft off command ignored");
    chk_s4_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S0 && os_req.sleep_s4 && !os_req.soft_off && !press.long_hold) |=> sys_state == PBS_S4)
        else $error("suspend to disk request ignored");
    chk_s3_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S0 && os_req.sleep_s3 && !os_req.sleep_s4 && !os_req.soft_off && !press.long_hold)
        |=> sys_state == PBS_S3)
        else $error("suspend to RAM request ignored");
    chk_off_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S5 && !press.short_press) |=> sys_state == PBS_S5)
        else $error("soft-off left without a switch press");
    // Rails and context
    chk_disk_ctx: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(sys_state == PBS_S4) |-> rails.ctx_disk && !rails.cpu_power)
        else $error("S4 rails wrong");
    chk_ram_ctx: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S3) |-> rails.ram_selfref && !rails.main_rails)
        else $error("S3 rails wrong");
    chk_s0_rails: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S0) |-> rails.main_rails && rails.cpu_power && !rails.ram_selfref
        && !rails.ctx_disk && !rails.cold_boot)
        else $error("S0 rails wrong");
    chk_cold_rail: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rails.cold_boot == (sys_state == PBS_S5))
        else $error("cold boot marker out of step with soft-off");
    // Refused sleep state
    chk_no_s1: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sys_state != PBS_S1)
        else $error("processor-stopped state entered");
    chk_state_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sys_state inside {PBS_S0, PBS_S3, PBS_S4, PBS_S5})
        else $error("state register holds an unused code");
    chk_s1_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sys_state == PBS_S0 && os_req.sleep_s1) |=> req_rejected)
        else $error("processor-stopped request not flagged");
    chk_s1_only_s0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_rejected |-> $past(os_req.sleep_s1) && $past(sys_state) == PBS_S0)
        else $error("refusal flagged without a request");
    // Management package
    chk_deep_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        deep_sx_enable |-> !oob_mgmt_enable && $past(mgmt_engine_s0_only_package))
        else $error("deep sleep without package");
    chk_oob_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
        oob_mgmt_enable != deep_sx_enable)
        else $error("out-of-band management and deep sleep together");
    cov_power_on: cover property (@(posedge ref_clk) sys_state == PBS_S5 ##1 sys_state == PBS_S0);
    cov_refused: cover property (@(posedge ref_clk) sys_state == PBS_S0 && req_rejected);
    cov_standby: cover property (@(posedge ref_clk) sys_state == PBS_S0 && press.short_press && os_req.btn_standby);
    cov_sleep_off: cover property (@(posedge ref_clk) sys_state == PBS_S3 ##1 sys_state == PBS_S5);
    cov_disk_wake: cover property (@(posedge ref_clk) sys_state == PBS_S4 ##1 sys_state == PBS_S0);
endmodule : pbs_sleep_ctrl

/* pkg/pbs_defines.svh */
// Purpose: Timing counts and encodings for the power button sleep-state controller
// Assumes: 40 MHz reference clock
// Notes: Counts are derived from times in their own units
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
// Clock period in nanoseconds
`define PBS_CLK_PERIOD_NS 25
// Short press limit in seconds
`define PBS_SHORT_HOLD_S 4
// Fail-safe hold threshold in seconds
`define PBS_LONG_HOLD_S 6
// Short limit in cycles, longest time, rounded down
`define PBS_SHORT_CYCLES ((`PBS_SHORT_HOLD_S * 64'd1000000000) / `PBS_CLK_PERIOD_NS)
// Long threshold in cycles, least time, rounded up
`define PBS_LONG_CYCLES (((`PBS_LONG_HOLD_S * 64'd1000000000) + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS)
// Hold counter width
`define PBS_CNT_W 32
`endif

/* pkg/pbs_pkg.sv */
// Purpose: Types for the power button sleep-state controller
// Assumes: Included defines give widths
// Notes: Types only
`include "pbs_defines.svh"
package pbs_pkg;
    // System sleep states
    typedef enum logic [2:0] {
        PBS_S0,
        PBS_S1,
        PBS_S3,
        PBS_S4,
        PBS_S5
    } pbs_state_t;
    // Operating system requests
    typedef struct packed {
        logic soft_off;    // Power off command
        logic sleep_s3;    // Suspend to RAM request
        logic sleep_s4;    // Suspend to disk request
        logic sleep_s1;    // Processor stopped request
        logic btn_standby; // Switch action set to standby
    } pbs_os_req_t;
    // Board rail controls
    typedef struct packed {
        logic main_rails;  // Non-standby voltages on
        logic cpu_power;   // Processor powered
        logic ram_selfref; // RAM kept in self refresh
        logic ctx_disk;    // Context held on disk
        logic cold_boot;   // Next wake needs cold boot
    } pbs_rails_t;
    // Press classification events
    typedef struct packed {
        logic short_press; // Released before short limit
        logic long_hold;   // Held to fail-safe threshold
    } pbs_press_t;
endpackage : pbs_pkg
